// file: verilog/core_event_ctrl.sv
// Design decisions made here: the Wishbone interface to the registers and the address map.
`include "core_event_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module core_event_ctrl
    import core_event_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Wishbone register slave
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [7:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    // Event sources
    input  wire logic [15:0]  irq_i,
    input  wire logic         exc_req_i,
    input  wire logic         exc_error_i,
    input  wire logic         emu_req_i,
    input  wire logic         force_valid_i,
    input  wire logic [3:0]   force_num_i,
    // Pipeline side
    input  wire pipe_status_t pipe_i,
    input  wire logic [31:0]  ret_addr_i,
    output logic              fetch_redirect_o,
    output logic      [31:0]  fetch_addr_o,
    output kill_t             kill_o,
    output mode_t             mode_o,
    output logic      [15:0]  event_pending_o,
    output logic      [15:0]  saved_mask_o
);

    // ------------------------------------------------------------------------
    // Input synchronisers and edge detection
    // ------------------------------------------------------------------------
    logic [15:0] sync1_reg;
    logic [15:0] sync2_reg;
    logic [15:0] sync3_reg;
    logic [15:0] irq_edge;

    // Pins are asynchronous; the first stage feeds only the second.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
            sync3_reg <= 16'h0000;
        end else begin
            sync1_reg <= irq_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign irq_edge = sync2_reg & ~sync3_reg;

    // ------------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------------
    logic [15:0] event_latch_reg,  event_latch_next;
    logic [15:0] event_mask_reg,   event_mask_next;
    logic [15:0] event_pending_reg, event_pending_next;
    logic [15:0] saved_mask_reg,   saved_mask_next;
    logic [31:0] int_ret_reg,      int_ret_next;
    logic [31:0] exc_ret_reg,      exc_ret_next;
    logic [31:0] nmi_ret_reg,      nmi_ret_next;
    logic [31:0] emu_ret_reg,      emu_ret_next;
    logic [31:0] vector_table [0:15];
    logic [31:0] vec_wdata;
    logic        vec_we;
    logic [3:0]  vec_idx;
    seq_state_t  state_reg,        state_next;
    logic [3:0]  winner_reg,       winner_next;
    logic        exc_error_reg,    exc_error_next;
    logic        redirect_reg,     redirect_next;
    logic [31:0] fetch_addr_reg,   fetch_addr_next;
    kill_t       kill_reg,         kill_next;
    mode_t       mode_reg,         mode_next;
    logic        ack_reg,          ack_next;
    logic [31:0] rdata_reg,        rdata_next;

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    // Lowest set bit, ignoring the global disable bit; NO_LEVEL if none.
    function automatic logic [4:0] lowest_level(input logic [15:0] v);
        logic [4:0] r;
        r = `NO_LEVEL;
        for (int i = `NUM_EVENTS - 1; i >= 0; i--) begin
            if (v[i] && i != `BIT_GLOBAL_DISABLE) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction

    // Byte-lane merge of a bus write into a word.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wr,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Mode implied by the pending set: emulation, supervisor or user.
    function automatic mode_t mode_of(input logic [15:0] p);
        mode_t m;
        m = MODE_USER;
        if (p[`EVT_EMULATION]) begin
            m = MODE_EMULATION;
        end else if (lowest_level(p) != `NO_LEVEL) begin
            m = MODE_SUPERVISOR;
        end
        return m;
    endfunction

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    logic        bus_req;
    logic        bus_wr;
    logic [31:0] sel_mask;
    logic [31:0] wr_merged_lo;

    // Ack is high for one cycle, then drops even if the master holds on.
    assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign bus_wr   = bus_req & wb_we_i;
    assign sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                       {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_merged_lo = wb_dat_i & sel_mask;
    assign vec_idx  = wb_adr_i[5:2];
    assign vec_we   = bus_wr && (wb_adr_i[7:6] == `OFS_VECTOR_BASE >> 6);
    assign vec_wdata = merge(vector_table[vec_idx], wb_dat_i, wb_sel_i);

    // ------------------------------------------------------------------------
    // Qualification and priority
    // ------------------------------------------------------------------------
    logic [15:0] eff_mask;
    logic [15:0] level_ok;
    logic [15:0] qualify;
    logic [4:0]  cur_level;
    logic [4:0]  pick;

    assign cur_level = lowest_level(event_pending_reg);
    // Low events are never maskable by software.
    assign eff_mask  = event_mask_reg | `MASK_FIXED_ONES;

    always_comb begin
        for (int i = 0; i < `NUM_EVENTS; i++) begin
            level_ok[i] = (5'(i) < cur_level) && (i != `BIT_GLOBAL_DISABLE)
                && !(event_pending_reg[`BIT_GLOBAL_DISABLE]
                     && i >= `FIRST_MASKABLE);
        end
    end

    assign qualify = event_latch_reg & eff_mask & level_ok;
    assign pick    = lowest_level(qualify);

    // ------------------------------------------------------------------------
    // Next-state logic for the event machine and registers
    // ------------------------------------------------------------------------
    always_comb begin
        logic [15:0] sets;
        logic [15:0] clears;
        logic [4:0]  top;
        sets               = 16'h0000;
        clears             = 16'h0000;
        top                = `NO_LEVEL;
        state_next         = state_reg;
        winner_next        = winner_reg;
        exc_error_next     = exc_error_reg;
        redirect_next      = 1'b0;
        fetch_addr_next    = fetch_addr_reg;
        kill_next          = '0;
        event_mask_next    = event_mask_reg;
        event_pending_next = event_pending_reg;
        saved_mask_next    = saved_mask_reg;
        int_ret_next       = int_ret_reg;
        exc_ret_next       = exc_ret_reg;
        nmi_ret_next       = nmi_ret_reg;
        emu_ret_next       = emu_ret_reg;

        sets = irq_edge;
        if (force_valid_i && force_num_i != `EVT_EMULATION
                && force_num_i != `EVT_EXCEPTION) begin
            sets[force_num_i] = 1'b1;
        end
        if (exc_req_i) begin
            sets[`EVT_EXCEPTION] = 1'b1;
            exc_error_next       = exc_error_i;
        end
        if (emu_req_i) begin
            sets[`EVT_EMULATION] = 1'b1;
        end
        if (bus_wr && wb_adr_i == `OFS_EVENT_LATCH) begin
            clears = wr_merged_lo[15:0];
        end

        // Bus writes to the mask and return registers.
        if (bus_wr) begin
            unique case (wb_adr_i)
                `OFS_EVENT_MASK: begin
                    // Only the low half exists; the cast drops the rest.
                    event_mask_next = 16'(merge({16'h0000, event_mask_reg},
                                                wb_dat_i, wb_sel_i));
                end
                `OFS_INT_RETURN: int_ret_next =
                    merge(int_ret_reg, wb_dat_i, wb_sel_i);
                `OFS_EXC_RETURN: exc_ret_next =
                    merge(exc_ret_reg, wb_dat_i, wb_sel_i);
                `OFS_NMI_RETURN: nmi_ret_next =
                    merge(nmi_ret_reg, wb_dat_i, wb_sel_i);
                `OFS_EMU_RETURN: emu_ret_next =
                    merge(emu_ret_reg, wb_dat_i, wb_sel_i);
                default: begin
                end
            endcase
        end

        if (pipe_i.cli_exec) begin
            saved_mask_next = event_mask_reg;
            event_mask_next = event_mask_next & `MASK_GLOBAL_CLEAR;
        end

        if (pipe_i.rti_df1) begin
            redirect_next   = 1'b1;
            fetch_addr_next = int_ret_reg;
        end

        if (pipe_i.push_ret_df2) begin
            event_pending_next[`BIT_GLOBAL_DISABLE] = 1'b0;
        end
        if (pipe_i.pop_ret_df2) begin
            event_pending_next[`BIT_GLOBAL_DISABLE] = 1'b1;
        end
        if (pipe_i.rti_wb) begin
            top = lowest_level(event_pending_reg);
            if (top != `NO_LEVEL) begin
                event_pending_next[top[3:0]] = 1'b0;
            end
            event_pending_next[`BIT_GLOBAL_DISABLE] = 1'b0;
        end

        unique case (state_reg)
            ST_IDLE: begin
                if (pick != `NO_LEVEL) begin
                    winner_next = pick[3:0];
                    state_next  = ST_PRIO;
                end
            end
            ST_PRIO: begin
                kill_next.younger = 1'b1;
                if (winner_reg == `EVT_EXCEPTION) begin
                    // exception kind sets the kill point
                    kill_next.current = exc_error_reg;
                end else begin
                    kill_next.ex1 = pipe_i.ex1_rti_or_cli;
                end
                state_next = ST_KILL;
            end
            ST_KILL: begin
                fetch_addr_next = vector_table[winner_reg];
                redirect_next   = 1'b1;
                clears[winner_reg]            = 1'b1;
                event_pending_next[winner_reg] = 1'b1;
                event_pending_next[`BIT_GLOBAL_DISABLE] = 1'b1;
                unique case (winner_reg)
                    `EVT_EMULATION: emu_ret_next = ret_addr_i;
                    `EVT_NMI:       nmi_ret_next = ret_addr_i;
                    `EVT_EXCEPTION: exc_ret_next = ret_addr_i;
                    default:        int_ret_next = ret_addr_i;
                endcase
                state_next = ST_ISSUE;
            end
            ST_ISSUE: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase

        // a new edge wins over the clear
        event_latch_next = (event_latch_reg & ~clears) | sets;
        // mode follows what is in service
        mode_next = mode_of(event_pending_next);
    end

    // Registering of the event machine.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            event_latch_reg   <= `RST_EVENT_LATCH;
            event_mask_reg    <= `RST_EVENT_MASK;
            event_pending_reg <= `RST_EVENT_PENDING;
            saved_mask_reg    <= `RST_EVENT_MASK;
            int_ret_reg       <= `RST_WORD;
            exc_ret_reg       <= `RST_WORD;
            nmi_ret_reg       <= `RST_WORD;
            emu_ret_reg       <= `RST_WORD;
            state_reg         <= ST_IDLE;
            winner_reg        <= 4'h0;
            exc_error_reg     <= 1'b0;
            redirect_reg      <= 1'b0;
            fetch_addr_reg    <= `RST_WORD;
            kill_reg          <= '0;
            mode_reg          <= MODE_SUPERVISOR;
        end else begin
            event_latch_reg   <= event_latch_next;
            event_mask_reg    <= event_mask_next;
            event_pending_reg <= event_pending_next;
            saved_mask_reg    <= saved_mask_next;
            int_ret_reg       <= int_ret_next;
            exc_ret_reg       <= exc_ret_next;
            nmi_ret_reg       <= nmi_ret_next;
            emu_ret_reg       <= emu_ret_next;
            state_reg         <= state_next;
            winner_reg        <= winner_next;
            exc_error_reg     <= exc_error_next;
            redirect_reg      <= redirect_next;
            fetch_addr_reg    <= fetch_addr_next;
            kill_reg          <= kill_next;
            mode_reg          <= mode_next;
        end
    end

    // The vector table is plain storage with no reset, so it maps to RAM.
    always_ff @(posedge clk_i) begin
        if (vec_we) begin
            vector_table[vec_idx] <= vec_wdata;
        end
    end

    // ------------------------------------------------------------------------
    // Bus read path
    // ------------------------------------------------------------------------
    // Unmapped addresses still ack and read as zero.
    always_comb begin
        ack_next   = bus_req;
        rdata_next = 32'h0000_0000;
        if (bus_req && !wb_we_i) begin
            if (wb_adr_i[7:6] == `OFS_VECTOR_BASE >> 6) begin
                rdata_next = vector_table[vec_idx];
            end else begin
                unique case (wb_adr_i)
                    `OFS_EVENT_LATCH:   rdata_next = {16'h0000, event_latch_reg};
                    `OFS_EVENT_MASK:    rdata_next = {16'h0000, eff_mask};
                    `OFS_EVENT_PENDING: rdata_next = {16'h0000,
                                                      event_pending_reg};
                    `OFS_INT_RETURN:    rdata_next = int_ret_reg;
                    `OFS_EXC_RETURN:    rdata_next = exc_ret_reg;
                    `OFS_NMI_RETURN:    rdata_next = nmi_ret_reg;
                    `OFS_EMU_RETURN:    rdata_next = emu_ret_reg;
                    `OFS_SAVED_MASK:    rdata_next = {16'h0000, saved_mask_reg};
                    default:            rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    // Registering of the bus answer.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------------
    // pending shows at least three cycles after the edge
    assign event_pending_o  = event_pending_reg;
    assign wb_ack_o         = ack_reg;
    assign wb_dat_o         = rdata_reg;
    assign fetch_redirect_o = redirect_reg;
    assign fetch_addr_o     = fetch_addr_reg;
    assign kill_o           = kill_reg;
    assign mode_o           = mode_reg;
    assign saved_mask_o     = saved_mask_reg;

endmodule : core_event_ctrl

`default_nettype wire

// file: verilog/core_event_regs.svh
`ifndef CORE_EVENT_REGS_SVH
`define CORE_EVENT_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------------------
`define OFS_EVENT_LATCH      8'h00
`define OFS_EVENT_MASK       8'h04
`define OFS_EVENT_PENDING    8'h08
`define OFS_INT_RETURN       8'h0C
`define OFS_EXC_RETURN       8'h10
`define OFS_NMI_RETURN       8'h14
`define OFS_EMU_RETURN       8'h18
`define OFS_SAVED_MASK       8'h1C
`define OFS_VECTOR_BASE      8'h40

// ----------------------------------------------------------------------------
// Event numbering and field positions
// ----------------------------------------------------------------------------
`define NUM_EVENTS           16
`define EVT_EMULATION        4'h0
`define EVT_RESET            4'h1
`define EVT_NMI              4'h2
`define EVT_EXCEPTION        4'h3
`define BIT_GLOBAL_DISABLE   4
`define FIRST_MASKABLE       5
`define NO_LEVEL             5'h10

// ----------------------------------------------------------------------------
// Reset values and fixed fields
// ----------------------------------------------------------------------------
`define RST_EVENT_LATCH      16'h0000
`define RST_EVENT_PENDING    16'h0000
`define RST_EVENT_MASK       16'h0000
`define MASK_FIXED_ONES      16'h001F
`define MASK_GLOBAL_CLEAR    16'h001F
`define RST_WORD             32'h0000_0000

`endif

// file: verilog/core_event_pkg.sv
package core_event_pkg;

    // Processor mode after an event is taken or returned from.
    typedef enum logic [2:0] {
        MODE_USER       = 3'b001,
        MODE_SUPERVISOR = 3'b010,
        MODE_EMULATION  = 3'b100
    } mode_t;

    // Entry sequence states, one cycle each except ST_IDLE, which waits for a winner.
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_PRIO  = 4'b0010,
        ST_KILL  = 4'b0100,
        ST_ISSUE = 4'b1000
    } seq_state_t;

    // Abort commands to the pipeline.
    typedef struct packed {
        logic younger;   // Kill everything younger than the execute stage.
        logic current;   // Kill the excepting instruction itself.
        logic ex1;       // Kill the instruction in the first execute stage.
    } kill_t;

    // Stage reports from the pipeline, one-cycle pulses.
    typedef struct packed {
        logic push_ret_df2;    // Push of the interrupt return reg in stage two.
        logic pop_ret_df2;     // Pop of the interrupt return reg in stage two.
        logic rti_df1;         // Interrupt return in first data-fetch stage.
        logic rti_wb;          // Interrupt return in writeback stage.
        logic ex1_rti_or_cli;  // Execute stage one holds return or disable.
        logic cli_exec;        // Global disable instruction executes.
    } pipe_status_t;

endpackage : core_event_pkg

// file: tb/pipe_model.sv
`timescale 1ns/1ps
`default_nettype none
module pipe_model
    import core_event_pkg::*;
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Event controller side
    input  wire logic         redirect_i,
    input  wire logic [31:0]  target_i,
    input  wire pipe_status_t op_i,
    output pipe_status_t      pipe_o,
    output logic      [31:0]  pc_o
);
    // Reports lag the request by one stage; the fetch point follows
    // every redirect, so a return lands on the next unexecuted word.
    // next instruction address
    always_ff @(posedge clk_i) begin
        pipe_o <= rst_i ? '0 : op_i;
        pc_o   <= rst_i ? 32'h0000_1000 : (redirect_i ? target_i : pc_o);
    end
endmodule // pipe_model
`default_nettype wire

// file: tb/core_event_chk.sv
`timescale 1ns/1ps
`default_nettype none
module core_event_chk
    import core_event_pkg::*;
(
    // Watched ports
    input wire logic         clk_i,
    input wire logic         rst_i,
    input wire logic [15:0]  irq_i,
    input wire pipe_status_t pipe_i,
    input wire logic         fetch_redirect_o,
    input wire kill_t        kill_o,
    input wire mode_t        mode_o,
    input wire logic [15:0]  event_pending_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Entry is a kill cycle followed by the issue cycle.
    sequence s_kill; kill_o.younger; endsequence
    sequence s_issue; fetch_redirect_o && event_pending_o[4]; endsequence
    a_entry_steps: assert property (s_kill |=> s_issue)
        else $error("entry did not issue after kill");
    a_kill_pulse: assert property (s_kill |=> !kill_o.younger)
        else $error("kill held too long");
    a_edge_latency: assert property ($rose(irq_i[7])
        |-> !$rose(event_pending_o[7]) [*3]) else $error("pending too early");
    a_emu_mode: assert property ($rose(event_pending_o[0])
        |-> mode_o == MODE_EMULATION) else $error("emulation mode missing");
    a_push_enable: assert property (pipe_i.push_ret_df2
        && !pipe_i.pop_ret_df2 && !kill_o.younger |=> !event_pending_o[4])
        else $error("push left disable set");
    a_pop_disable: assert property (pipe_i.pop_ret_df2 && !pipe_i.rti_wb
        |=> event_pending_o[4]) else $error("pop left disable clear");
    a_rti_refetch: assert property (pipe_i.rti_df1 |=> fetch_redirect_o)
        else $error("return did not refetch");
    a_wb_enable: assert property (pipe_i.rti_wb && !kill_o.younger
        |=> !event_pending_o[4]) else $error("return left disable set");
endmodule // core_event_chk
bind core_event_ctrl core_event_chk core_event_chk_i (.clk_i, .rst_i,
    .irq_i, .pipe_i, .fetch_redirect_o, .kill_o, .mode_o, .event_pending_o);
`default_nettype wire

// file: tb/test_core_event_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_core_event_ctrl;
    import core_event_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, redir;
    logic exc = 0, emu = 0, frc = 0;
    logic [3:0]   fnum = 4'h0;
    logic [7:0]   adr = 8'h00;
    logic [15:0]  irq = 16'h0000, pend, smask;
    logic [31:0]  wdat = 32'h0000_0000, rdat, pc, faddr, q;
    logic [2:0]   ks;
    pipe_status_t op = '0, pipe;
    kill_t        kill;
    mode_t        mode;
    int           err_count = 0, checked = 0, n;
    // Free-running core clock, 25 ns period.
    always #12.5 clk_i = ~clk_i;
    core_event_ctrl core_event_ctrl_i (.clk_i, .rst_i, .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .irq_i(irq),
        .exc_req_i(exc), .exc_error_i(exc), .emu_req_i(emu),
        .force_valid_i(frc), .force_num_i(fnum), .pipe_i(pipe),
        .ret_addr_i(pc), .fetch_redirect_o(redir), .fetch_addr_o(faddr),
        .kill_o(kill), .mode_o(mode), .event_pending_o(pend),
        .saved_mask_o(smask));
    pipe_model pipe_model_i (.clk_i, .rst_i, .redirect_i(redir),
        .target_i(faddr), .op_i(op), .pipe_o(pipe), .pc_o(pc));
    // ------------------------------------------------------------
    // Bus, pulse and compare helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // Wishbone classic cycle: hold everything until ack is sampled.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
        wb(0, a, 32'h0000_0000);
        chk(nm, e, q);
    endtask
    task automatic pulse(input pipe_status_t v);
        @(posedge clk_i);
        op <= v;
        @(posedge clk_i);
        op <= '0;
        repeat (3) @(posedge clk_i);
    endtask
    // Waits for the redirect, collecting every kill seen on the way.
    task automatic entry;
        n = 0;
        ks = 3'b000;
        do begin
            @(posedge clk_i);
            n++;
            ks = ks | kill;
        end while (redir !== 1'b1 && n < 40);
    endtask
    task automatic finish_test;
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Main sequence; the bus writes set vectors 0, 7 and 8 first.
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        rd("mask", 8'h04, 32'h0000_001F);
        rd("pending", 8'h08, 32'h0000_0000);
        wb(1, 8'h40, 32'h0000_0100);
        wb(1, 8'h5C, 32'h0000_0700);
        wb(1, 8'h60, 32'h0000_0800);
        wb(1, 8'h20, 32'h0000_1234);
        rd("unmapped", 8'h20, 32'h0000_0000);
        wb(1, 8'h04, 32'h0000_0080);
        {op, irq[7]} <= {6'h02, 1'b1};
        entry;
        op <= '0;
        chk("latency", 32'h0000_0001, 32'(n > 3));
        chk("target", 32'h0000_0700, faddr);
        chk("pending", 32'h0000_0090, 32'(pend));
        chk("mode", 32'(MODE_SUPERVISOR), 32'(mode));
        chk("kill_ex1", 32'h0000_0001, 32'(ks[0]));
        rd("latch", 8'h00, 32'h0000_0000);
        rd("int_ret", 8'h0C, 32'h0000_1000);
        irq[7] <= 0;
        @(posedge clk_i);
        irq[7] <= 1;
        repeat (6) @(posedge clk_i);
        rd("latch", 8'h00, 32'h0000_0080);
        wb(1, 8'h00, 32'h0000_FF7F);
        rd("latch", 8'h00, 32'h0000_0080);
        wb(1, 8'h00, 32'h0000_0080);
        rd("latch", 8'h00, 32'h0000_0000);
        $display("test interrupt entry done");
        emu <= 1;
        @(posedge clk_i);
        emu <= 0;
        entry;
        chk("target", 32'h0000_0100, faddr);
        chk("mode", 32'(MODE_EMULATION), 32'(mode));
        rd("emu_ret", 8'h18, 32'h0000_0700);
        pulse(6'h20);
        rd("pending", 8'h08, 32'h0000_0081);
        pulse(6'h10);
        rd("pending", 8'h08, 32'h0000_0091);
        pulse(6'h08);
        chk("refetch", 32'h0000_1000, faddr);
        pulse(6'h04);
        rd("pending", 8'h08, 32'h0000_0080);
        pulse(6'h04);
        rd("pending", 8'h08, 32'h0000_0000);
        chk("mode", 32'(MODE_USER), 32'(mode));
        pulse(6'h01);
        rd("mask", 8'h04, 32'h0000_001F);
        chk("saved", 32'h0000_0080, 32'(smask & 16'hFFE0));
        $display("test return path done");
        {frc, fnum} <= {1'b1, 4'h9};
        @(posedge clk_i);
        fnum <= 4'h8;
        @(posedge clk_i);
        frc <= 0;
        rd("latch", 8'h00, 32'h0000_0300);
        wb(1, 8'h04, 32'h0000_0300);
        entry;
        chk("target", 32'h0000_0800, faddr);
        exc <= 1;
        @(posedge clk_i);
        exc <= 0;
        entry;
        chk("kill_cur", 32'h0000_0001, 32'(ks[1]));
        rd("exc_ret", 8'h10, 32'h0000_0800);
        $display("test priority done");
        finish_test;
    end
    // Watchdog, well beyond the roughly 135 cycles the tests need.
    initial begin
        repeat (4000) @(posedge clk_i);
        err_count++;
        finish_test;
    end
endmodule // test_core_event_ctrl
`default_nettype wire
